/* rtl/rce_encoder.sv */
`timescale 1ns/10ps
// Summary of operation
// - Request rise captures address and data, sends the packet three times.
// - While request stays high, a new three-word cycle follows each finished one.
// - After request falls, the running cycle completes, then the encoder idles.
// - Packet order is address bit 0..9, then data bit 0..7.
// - The packet leaves as one serial stream driving the transmitter modulation.
// - Unconnected data inputs read as low.
// - Unconnected address inputs read as high.
// - Data style select picks zero or open for low data; defaults low.
// - Address style selects pick mapping; select 0 defaults low, select 1 high.
// - High data is one; low data is zero if style is 1, else open.
// - Address styles 00 one/zero, 01 one/open, 10 open/zero, 11 one/zero.
// - Inputs are re-sampled at each new cycle start.
module rce_encoder
  import rce_pkg::*;
#(
  parameter logic [15:0] SLOT_CYCLES = SLOT_CYCLES_DEF[15:0]
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 send_request,
  input  wire logic [DATA_BITS-1:0] data_inputs,
  input  wire logic [DATA_BITS-1:0] data_inputs_connected,
  input  wire logic [ADDR_BITS-1:0] address_inputs,
  input  wire logic [ADDR_BITS-1:0] address_inputs_connected,
  input  wire logic                 data_style_select,
  input  wire logic                 data_style_select_connected,
  input  wire logic                 address_style_select_0,
  input  wire logic                 address_style_select_0_connected,
  input  wire logic                 address_style_select_1,
  input  wire logic                 address_style_select_1_connected,
  output logic                      tx_modulation,
  output logic                      tx_active
);

  logic [PIN_W-1:0]      pin_raw;
  logic [PIN_W-1:0]      pin_sync;
  logic [ADDR_BITS-1:0]  addr_lvl;
  logic [DATA_BITS-1:0]  data_lvl;
  logic                  dcfg;
  logic                  acfg0;
  logic                  acfg1;
  logic                  req_lvl;
  logic [2*PKT_BITS-1:0] pkt_types;
  logic [PKT_BITS-1:0]   pkt_levels;

  rce_state_t            state;
  rce_state_t            next_state;
  logic [2*PKT_BITS-1:0] types;
  logic [2*PKT_BITS-1:0] next_types;
  logic [PKT_BITS-1:0]   snapshot;
  logic [PKT_BITS-1:0]   next_snapshot;
  logic [15:0]           slot_timer;
  logic [15:0]           next_slot_timer;
  logic [1:0]            slot_idx;
  logic [1:0]            next_slot_idx;
  logic [4:0]            bit_idx;
  logic [4:0]            next_bit_idx;
  logic [1:0]            word_idx;
  logic [1:0]            next_word_idx;
  logic [7:0]            cycle_count;
  logic [7:0]            next_cycle_count;
  logic                  next_tx_modulation;
  logic                  next_tx_active;
  logic [3:0]            next_pattern;
  logic                  cycle_end;
  logic [15:0]           slot_len;
  logic [15:0]           next_slot_len;
  logic [31:0]           next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;

  // Every pin, level and connection flag alike, is synchronised before use
  assign pin_raw = {send_request,
                    address_style_select_1_connected, address_style_select_1,
                    address_style_select_0_connected, address_style_select_0,
                    data_style_select_connected, data_style_select,
                    address_inputs_connected, address_inputs,
                    data_inputs_connected, data_inputs};

  rce_sync #(.WIDTH(PIN_W)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .pin_in   (pin_raw),
    .pin_sync (pin_sync)
  );

  // Weak pulls decide the level of an unconnected pin
  assign req_lvl = pin_sync[PIN_W-1];
  assign acfg1   = pin_sync[PIN_W-2] ? pin_sync[PIN_W-3] : 1'b1;
  assign acfg0   = pin_sync[PIN_W-4] ? pin_sync[PIN_W-5] : 1'b0;
  assign dcfg    = pin_sync[PIN_W-6] ? pin_sync[PIN_W-7] : 1'b0;

  // Per-pin resolution and bit type mapping
  genvar gi;
  generate
    for (gi = 0; gi < PKT_BITS; gi++) begin : g_bit
      if (gi < ADDR_BITS) begin : g_addr
        assign addr_lvl[gi] = pin_sync[DATA_BITS*2+ADDR_BITS+gi] ?
                              pin_sync[DATA_BITS*2+gi] : 1'b1;
        assign pkt_levels[gi] = addr_lvl[gi];
        // Style 10 turns a high into open, style 01 turns a low into open
        assign pkt_types[2*gi +: 2] = addr_lvl[gi] ?
                                      ((acfg1 && !acfg0) ? BIT_OPEN : BIT_ONE) :
                                      ((!acfg1 && acfg0) ? BIT_OPEN : BIT_ZERO);
      end else begin : g_data
        assign data_lvl[gi-ADDR_BITS] = pin_sync[DATA_BITS+gi-ADDR_BITS] ?
                                        pin_sync[gi-ADDR_BITS] : 1'b0;
        assign pkt_levels[gi] = data_lvl[gi-ADDR_BITS];
        assign pkt_types[2*gi +: 2] = data_lvl[gi-ADDR_BITS] ? BIT_ONE :
                                      (dcfg ? BIT_ZERO : BIT_OPEN);
      end
    end
  endgenerate

  // Slot pattern of a bit type
  function automatic logic [3:0] rce_pattern(input logic [1:0] kind);
    logic [3:0] pat;
    pat = PAT_ZERO;
    if (kind == BIT_ONE) begin
      pat = PAT_ONE;
    end else if (kind == BIT_OPEN) begin
      pat = PAT_OPEN;
    end
    return pat;
  endfunction

  assign cycle_end = (state == RCE_SEND) && (slot_timer == slot_len - 16'h0001) &&
                     (slot_idx == 2'(SLOTS_PER_BIT - 1)) && (bit_idx == 5'(GAP_BIT)) &&
                     (word_idx == 2'(WORDS_PER_CYCLE - 1));

  // Encoder sequencer: slot timer, slot, bit and word counters
  always_comb begin
    next_state       = state;
    next_types       = types;
    next_snapshot    = snapshot;
    next_slot_timer  = slot_timer;
    next_slot_idx    = slot_idx;
    next_bit_idx     = bit_idx;
    next_word_idx    = word_idx;
    next_cycle_count = cycle_count;
    case (state)
      RCE_IDLE: begin
        if (req_lvl) begin
          next_state      = RCE_SEND;
          next_types      = pkt_types;
          next_snapshot   = pkt_levels;
          next_slot_timer = 16'h0000;
          next_slot_idx   = 2'h0;
          next_bit_idx    = 5'h00;
          next_word_idx   = 2'h0;
        end
      end
      RCE_SEND: begin
        if (slot_timer != slot_len - 16'h0001) begin
          next_slot_timer = slot_timer + 16'h0001;
        end else begin
          next_slot_timer = 16'h0000;
          if (slot_idx != 2'(SLOTS_PER_BIT - 1)) begin
            next_slot_idx = slot_idx + 2'h1;
          end else begin
            next_slot_idx = 2'h0;
            if (bit_idx != 5'(GAP_BIT)) begin
              next_bit_idx = bit_idx + 5'h01;
            end else begin
              next_bit_idx = 5'h00;
              if (word_idx != 2'(WORDS_PER_CYCLE - 1)) begin
                next_word_idx = word_idx + 2'h1;
              end else begin
                next_word_idx    = 2'h0;
                next_cycle_count = cycle_count + 8'h01;
                if (req_lvl) begin
                  next_types    = pkt_types;
                  next_snapshot = pkt_levels;
                end else begin
                  next_state = RCE_IDLE;
                end
              end
            end
          end
        end
      end
      default: begin
        next_state = RCE_IDLE;
      end
    endcase
    // Output follows the next counters so that it leaves a flip-flop
    next_tx_active     = (next_state == RCE_SEND);
    next_pattern       = PAT_ZERO;
    next_tx_modulation = 1'b0;
    if (next_state == RCE_SEND && next_bit_idx != 5'(GAP_BIT)) begin
      // The gap cell index lies past the type vector, so it is never looked up
      next_pattern       = rce_pattern(next_types[2*next_bit_idx +: 2]);
      next_tx_modulation = next_pattern[2'(SLOTS_PER_BIT - 1) - next_slot_idx];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state         <= RCE_IDLE;
      types         <= '0;
      snapshot      <= '0;
      slot_timer    <= 16'h0000;
      slot_idx      <= 2'h0;
      bit_idx       <= 5'h00;
      word_idx      <= 2'h0;
      cycle_count   <= 8'h00;
      tx_modulation <= 1'b0;
      tx_active     <= 1'b0;
    end else begin
      state         <= next_state;
      types         <= next_types;
      snapshot      <= next_snapshot;
      slot_timer    <= next_slot_timer;
      slot_idx      <= next_slot_idx;
      bit_idx       <= next_bit_idx;
      word_idx      <= next_word_idx;
      cycle_count   <= next_cycle_count;
      tx_modulation <= next_tx_modulation;
      tx_active     <= next_tx_active;
    end
  end

  // APB slave: data is prepared in setup, so access always takes one wait-free cycle
  always_comb begin
    next_slot_len = slot_len;
    next_pready   = psel && !penable;
    next_prdata   = 32'h0000_0000;
    next_pslverr  = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        REG_SLOT_LEN: next_prdata = {16'h0000, slot_len};
        REG_STATUS: begin
          next_prdata[ST_BUSY_BIT]                = (state == RCE_SEND);
          next_prdata[ST_WORD_LSB +: 2]           = word_idx;
          next_prdata[ST_REQ_BIT]                 = req_lvl;
          next_prdata[ST_CYCLES_LSB +: 8]         = cycle_count;
        end
        REG_SNAPSHOT: next_prdata = {14'h0000, snapshot};
        default: next_pslverr = 1'b1;  // Unmapped address answers with an error
      endcase
    end
    // A zero slot length would wrap the timer compare and stretch each slot to 65536 clocks, so it is clamped
    if (psel && penable && pready && pwrite && paddr == REG_SLOT_LEN) begin
      next_slot_len = (pwdata[15:0] < SLOT_LEN_MIN) ? SLOT_LEN_MIN : pwdata[15:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_len <= SLOT_CYCLES;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      slot_len <= next_slot_len;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_idle_quiet: assert property (state == RCE_IDLE && !req_lvl |=> !tx_modulation)
    else $error("modulation active while idle");
  a_start_capture: assert property (state == RCE_IDLE && req_lvl |=> state == RCE_SEND
    && types == $past(pkt_types))
    else $error("request did not start a capture");
  a_three_words: assert property (word_idx < 2'(WORDS_PER_CYCLE))
    else $error("word index past three");
  a_restart_hold: assert property (cycle_end && req_lvl |=> state == RCE_SEND
    && word_idx == 2'h0 && types == $past(pkt_types))
    else $error("cycle did not restart with fresh sample");
  a_stop_after: assert property (cycle_end && !req_lvl |=> state == RCE_IDLE && !tx_modulation)
    else $error("encoder did not stop after cycle");
  a_no_early_stop: assert property (state == RCE_SEND && !cycle_end |=> state == RCE_SEND)
    else $error("cycle cut short");
  a_gap_silent: assert property (state == RCE_SEND && bit_idx == 5'(GAP_BIT)
    && !cycle_end |-> !tx_modulation)
    else $error("modulation active in word gap");
  a_data_pull: assert property (!pin_sync[2*DATA_BITS-1]
    |-> pkt_types[2*PKT_BITS-2 +: 2] == (dcfg ? BIT_ZERO : BIT_OPEN))
    else $error("floating data not low");
  a_addr_map: assert property (addr_lvl[0] && acfg1 && !acfg0
    |-> pkt_types[1:0] == BIT_OPEN)
    else $error("address high not open for style 10");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle");

  c_single_cycle: cover property (cycle_end && !req_lvl);
  c_repeat_cycle: cover property (cycle_end && req_lvl);
  c_slot_write: cover property (psel && penable && pready && pwrite
    && paddr == REG_SLOT_LEN);

endmodule

/* rtl/rce_pkg.sv */
package rce_pkg;

  // Packet layout
  localparam int ADDR_BITS       = 10;
  localparam int DATA_BITS       = 8;
  localparam int PKT_BITS        = ADDR_BITS + DATA_BITS;
  localparam int WORDS_PER_CYCLE = 3;
  localparam int SLOTS_PER_BIT   = 4;
  localparam int GAP_BIT         = PKT_BITS;   // One silent bit cell closes each word

  // Bit types carried on the air
  localparam logic [1:0] BIT_ZERO = 2'h0;
  localparam logic [1:0] BIT_ONE  = 2'h1;
  localparam logic [1:0] BIT_OPEN = 2'h2;

  // Slot patterns of one bit cell, sent from the top bit down
  localparam logic [3:0] PAT_ONE  = 4'he;
  localparam logic [3:0] PAT_ZERO = 4'h8;
  localparam logic [3:0] PAT_OPEN = 4'ha;

  // Timing: a whole three-word cycle fits the refresh lag
  localparam int CLOCK_KHZ       = 20000;
  localparam int CYCLE_TIME_MS   = 150;
  localparam int SLOTS_PER_CYCLE = WORDS_PER_CYCLE * (PKT_BITS + 1) * SLOTS_PER_BIT;
  localparam int SLOT_CYCLES_DEF = (CYCLE_TIME_MS * CLOCK_KHZ) / SLOTS_PER_CYCLE;
  localparam logic [15:0] SLOT_LEN_MIN = 16'h0001;

  // APB register map
  localparam logic [11:0] REG_SLOT_LEN = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_SNAPSHOT = 12'h008;

  // Status fields
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_WORD_LSB   = 1;
  localparam int ST_REQ_BIT    = 3;
  localparam int ST_CYCLES_LSB = 8;

  // Synchronised pin vector layout
  localparam int PIN_W = 2 * (PKT_BITS + 3) + 1;

  typedef enum logic {RCE_IDLE, RCE_SEND} rce_state_t;

endpackage

/* rtl/rce_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for pins that arrive from outside the clock domain
module rce_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= '0;
      pin_sync <= '0;
    end else begin
      stage1   <= pin_in;
      pin_sync <= stage1;
    end
  end

endmodule

/* tb/rce_receiver.sv */
`timescale 1ns/10ps
// Far-end receiver: decodes slot patterns, checks address, copies data
module rce_receiver
  import rce_pkg::*;
#(
  parameter int SLOT = 4
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   tx_modulation,
  input  wire logic                   tx_active,
  input  wire logic [2*ADDR_BITS-1:0] own_address,
  output logic      [DATA_BITS-1:0]   data_outputs,
  output logic      [2*PKT_BITS-1:0]  last_word,
  output int                          word_count
);
  int                  clk_n;
  int                  s;
  int                  c;
  logic [3:0]          p;
  logic [1:0]          t;
  logic [2*PKT_BITS-1:0] acc;

  // Sample mid-slot so edge jitter of the stream cannot flip a slot
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_n = 0;
      p = 4'h0;
      data_outputs <= 8'h00;
      last_word <= '0;
      word_count <= 0;
    end else if (!tx_active) begin
      clk_n = 0;
    end else begin
      if (clk_n % SLOT == SLOT / 2) begin
        s = clk_n / SLOT;
        p = {p[2:0], tx_modulation};
        if (s % SLOTS_PER_BIT == SLOTS_PER_BIT - 1) begin
          c = (s / SLOTS_PER_BIT) % (PKT_BITS + 1);
          t = (p == PAT_ONE) ? BIT_ONE : (p == PAT_ZERO) ? BIT_ZERO :
              (p == PAT_OPEN) ? BIT_OPEN : 2'h3;
          if (c < PKT_BITS) begin
            acc[2*c+:2] = t;
          end else begin
            // A noisy gap cell spoils the word on purpose
            last_word <= (p == 4'h0) ? acc : '1;
            word_count <= word_count + 1;
            if (acc[2*ADDR_BITS-1:0] == own_address) begin
              for (int i = 0; i < DATA_BITS; i++) begin
                data_outputs[i] <= (acc[2*(ADDR_BITS+i)+:2] == BIT_ONE);
              end
            end
          end
        end
      end
      clk_n = clk_n + 1;
    end
  end
endmodule

/* tb/remote_control_encoder_tb.sv */
`timescale 1ns/10ps
module remote_control_encoder_tb
  import rce_pkg::*;
;
  logic                  clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic                  send_request, ds, dsc, s0, s0c, s1, s1c, tx_modulation, tx_active;
  logic [11:0]           paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [7:0]            d, dc, dout;
  logic [9:0]            a, ac;
  logic [2*PKT_BITS-1:0] lw, ew, ew2;
  logic [19:0]           own;
  int                    word_count, err_count, checks_done, base;

  rce_encoder #(.SLOT_CYCLES(16'h0004)) u_rce_encoder (.clock(clock), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .send_request(send_request),
    .data_inputs(d), .data_inputs_connected(dc), .address_inputs(a),
    .address_inputs_connected(ac), .data_style_select(ds),
    .data_style_select_connected(dsc), .address_style_select_0(s0),
    .address_style_select_0_connected(s0c), .address_style_select_1(s1),
    .address_style_select_1_connected(s1c), .tx_modulation(tx_modulation),
    .tx_active(tx_active));

  rce_receiver #(.SLOT(4)) u_rce_receiver (.clock(clock), .rst_n(rst_n),
    .tx_modulation(tx_modulation), .tx_active(tx_active), .own_address(own),
    .data_outputs(dout), .last_word(lw), .word_count(word_count));

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Bit types expected on the air, pulls applied to floating pins
  function automatic logic [2*PKT_BITS-1:0] exp_w(input logic [9:0] ad, adc,
      input logic [7:0] dd, ddc);
    logic [2*PKT_BITS-1:0] w;
    logic                  de, e0, e1, lv;
    de = dsc ? ds : 1'b0;
    e0 = s0c ? s0 : 1'b0;
    e1 = s1c ? s1 : 1'b1;
    for (int i = 0; i < ADDR_BITS; i++) begin
      lv = adc[i] ? ad[i] : 1'b1;
      w[2*i+:2] = lv ? ((e1 && !e0) ? BIT_OPEN : BIT_ONE)
                     : ((!e1 && e0) ? BIT_OPEN : BIT_ZERO);
    end
    for (int i = 0; i < DATA_BITS; i++) begin
      lv = ddc[i] ? dd[i] : 1'b0;
      w[2*(ADDR_BITS+i)+:2] = lv ? BIT_ONE : (de ? BIT_ZERO : BIT_OPEN);
    end
    return w;
  endfunction

  task chk(input string nm, input logic [2*PKT_BITS-1:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      err_count++;
    end
  endtask

  // One APB transfer; result left in rd and err
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_words(input int t);
    while (word_count < t) begin
      @(posedge clock);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    results();
  end

  initial begin
    {rst_n, psel, penable, pwrite, send_request, ds, s0, s1} = '0;
    {dsc, s0c, s1c} = 3'h7;
    paddr = 12'h000;
    pwdata = 32'h0;
    d = 8'h00;
    dc = 8'hff;
    a = 10'h2b5;
    ac = 10'h3ff;
    own = 20'h0;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    chk("idle_mod", 36'h0, {35'h0, tx_modulation});
    apb(1'b0, REG_SLOT_LEN, 32'h0);
    chk("slot_len", 36'h4, {4'h0, rd});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", 36'h1, {35'h0, err});
    apb(1'b1, REG_SLOT_LEN, 32'h0);
    apb(1'b0, REG_SLOT_LEN, 32'h0);
    chk("slot_min", 36'h1, {4'h0, rd});
    apb(1'b1, REG_SLOT_LEN, 32'h4);
    // Every style code, then all selects floating with mixed floating pins
    for (int k = 0; k < 5; k++) begin
      if (k < 4) begin
        {s1, s0} <= k[1:0];
        ds <= k[0];
        d <= 8'h5a ^ k[7:0];
      end else begin
        {ds, s0, s1, dsc, s0c, s1c} <= 6'h30;
        a <= 10'h000;
        ac <= 10'h00f;
        d <= 8'hff;
        dc <= 8'h0f;
      end
      @(posedge clock);
      ew = exp_w(a, ac, d, dc);
      ew2 = exp_w(a, ac, ~d, dc);
      own <= ew[19:0];
      base = word_count;
      send_request <= 1'b1;
      wait_words(base + 1);
      d <= ~d;
      if (k == 4) wait_words(base + 4);
      send_request <= 1'b0;
      @(posedge clock);
      while (tx_active !== 1'b0) begin
        @(posedge clock);
      end
      repeat (2) @(posedge clock);
      chk("words", (k == 4) ? 36'h6 : 36'h3, 36'(word_count - base));
      chk("word", (k == 4) ? ew2 : ew, lw);
      chk("dout", {28'h0, ((k == 4) ? d : ~d) & dc}, {28'h0, dout});
      chk("idle_mod", 36'h0, {35'h0, tx_modulation});
    end
    // Register view of the last capture and of the finished cycle count
    apb(1'b0, REG_SNAPSHOT, 32'h0);
    chk("snapshot", 36'h0_0000_03f0, {4'h0, rd});
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status", 36'h0_0000_0600, {4'h0, rd});
    results();
  end
endmodule
